/* hdl/lrm_config.sv */
// SPI-reached configuration registers and data buffer of the long-range modem
`timescale 1ns/1ps
module lrm_config (
    input  wire logic          core_clk,     // 250 MHz clock
    input  wire logic          nrst,         // Async reset, active low
    input  wire logic          spi_sck,      // SPI clock pin
    input  wire logic          spi_mosi,     // SPI data in pin
    input  wire logic          spi_nss_n,    // SPI select, active low
    output logic               spi_miso,     // SPI data out
    output logic               spi_miso_oe,  // High while driving data out
    input  wire logic [7:0]    mdm_rd_addr,  // Modem-side buffer address
    output logic      [7:0]    mdm_rd_data,  // Modem-side buffer data
    output lrm_pkg::lrm_cfg_t  cfg_out       // Decoded modem settings
);
    // ****************************************************************
    // Reset release and pin synchronisers
    // ****************************************************************
    logic [1:0] rst_sync;
    logic       rst_n;
    logic [2:0] sck_s, mosi_s, nss_s;
    logic       sck_f, mosi_f, nss_f, sck_new, nss_new, mosi_new, sck_rise, sck_fall;
    // Release is delayed two edges so every flop leaves reset together
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Three flops per pin; a level counts only when stages two and three agree
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_s  <= 3'h0;
            mosi_s <= 3'h0;
            nss_s  <= 3'h7;
            sck_f  <= 1'b0;
            mosi_f <= 1'b0;
            nss_f  <= 1'b1;
        end else begin
            sck_s  <= {sck_s[1:0], spi_sck};
            mosi_s <= {mosi_s[1:0], spi_mosi};
            nss_s  <= {nss_s[1:0], spi_nss_n};
            sck_f  <= sck_new;
            mosi_f <= mosi_new;
            nss_f  <= nss_new;
        end
    end
    assign sck_new  = (sck_s[1] == sck_s[2]) ? sck_s[2] : sck_f;
    assign mosi_new = (mosi_s[1] == mosi_s[2]) ? mosi_s[2] : mosi_f;
    assign nss_new  = (nss_s[1] == nss_s[2]) ? nss_s[2] : nss_f;
    assign sck_rise = !nss_f && !sck_f && sck_new;
    assign sck_fall = !nss_f && sck_f && !sck_new;

    // ****************************************************************
    // SPI framing: address byte then data bytes, MSB first
    // ****************************************************************
    lrm_pkg::lrm_phase_t phase;
    logic [6:0] rx_sh, addr;
    logic [2:0] bit_cnt;
    logic [7:0] rx_byte, tx_sh, op_mode, fifo_ptr;
    logic       byte_ev, data_ev, wr_ev, rd_ev, wnr, lr_sel, fifo_hit;
    assign rx_byte  = {rx_sh, mosi_f};
    assign byte_ev  = sck_rise && (bit_cnt == 3'h7);
    assign data_ev  = byte_ev && (phase == lrm_pkg::PH_DATA);
    assign wr_ev    = data_ev && wnr;
    assign rd_ev    = data_ev && !wnr;
    assign lr_sel   = op_mode[lrm_pkg::LR_SEL_BIT];
    assign fifo_hit = lr_sel && (addr == lrm_pkg::FIFO_ADDR);

    // Bit counter and phase; deselect aborts any partial byte
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase   <= lrm_pkg::PH_IDLE;
            rx_sh   <= 7'h00;
            bit_cnt <= 3'h0;
            addr    <= 7'h00;
            wnr     <= 1'b0;
        end else if (nss_f) begin
            phase   <= lrm_pkg::PH_IDLE;
            bit_cnt <= 3'h0;
        end else begin
            if (phase == lrm_pkg::PH_IDLE) begin
                phase <= lrm_pkg::PH_ADDR;
            end
            if (sck_rise) begin
                rx_sh   <= rx_byte[6:0];
                bit_cnt <= bit_cnt + 3'h1;
            end
            if (byte_ev) begin
                case (phase)
                    lrm_pkg::PH_ADDR: begin
                        addr  <= rx_byte[6:0];
                        wnr   <= rx_byte[7];
                        phase <= lrm_pkg::PH_DATA;
                    end
                    // Buffer window stays put so bursts stream the buffer
                    lrm_pkg::PH_DATA: addr <= fifo_hit ? addr : addr + 7'h01;
                    default: phase <= lrm_pkg::PH_ADDR;
                endcase
            end
        end
    end

    // ****************************************************************
    // Register maps, operating mode and buffer pointer
    // ****************************************************************
    logic [7:0] lr_map  [lrm_pkg::MAP_WORDS];
    logic [7:0] fsk_map [lrm_pkg::MAP_WORDS];
    logic [7:0] fifo_mem[lrm_pkg::FIFO_WORDS];

    // Two full maps share the addresses; the select bit picks one
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_mode  <= lrm_pkg::OP_MODE_RST;
            fifo_ptr <= 8'h00;
            for (int i = 0; i < lrm_pkg::MAP_WORDS; i++) begin
                lr_map[i]  <= 8'h00;
                fsk_map[i] <= 8'h00;
            end
            lr_map[lrm_pkg::CFG1_ADDR] <= lrm_pkg::CFG1_RST;
            lr_map[lrm_pkg::CFG2_ADDR] <= lrm_pkg::CFG2_RST;
        end else if (wr_ev) begin
            if (addr == lrm_pkg::OP_MODE_ADDR) begin
                // Modem swap only from Sleep; otherwise the select bit holds
                op_mode <= (op_mode[2:0] == lrm_pkg::MODE_SLEEP) ? rx_byte
                         : {op_mode[7], rx_byte[6:0]};
            end else if (lr_sel && addr == lrm_pkg::FIFO_PTR_ADDR) begin
                fifo_ptr <= rx_byte;
            end else if (fifo_hit) begin
                fifo_ptr <= fifo_ptr + 8'h01;
            end else if (lr_sel) begin
                lr_map[addr] <= rx_byte;
            end else begin
                fsk_map[addr] <= rx_byte;
            end
        end else if (rd_ev && fifo_hit) begin
            fifo_ptr <= fifo_ptr + 8'h01;
        end
    end

    // Buffer: SPI write port and an independent modem read port
    always_ff @(posedge core_clk) begin
        if (wr_ev && fifo_hit) begin
            fifo_mem[fifo_ptr] <= rx_byte;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mdm_rd_data <= 8'h00;
        end else begin
            mdm_rd_data <= fifo_mem[mdm_rd_addr];
        end
    end

    // ****************************************************************
    // Read path: value for the next byte out
    // ****************************************************************
    logic [6:0] next_rd_addr;
    logic [7:0] next_rd_ptr, rd_data;
    always_comb begin
        next_rd_addr = (phase == lrm_pkg::PH_ADDR) ? rx_byte[6:0]
                     : (fifo_hit ? addr : addr + 7'h01);
        next_rd_ptr  = (phase == lrm_pkg::PH_ADDR) ? fifo_ptr : fifo_ptr + 8'h01;
        if (next_rd_addr == lrm_pkg::OP_MODE_ADDR) begin
            rd_data = op_mode;
        end else if (lr_sel && next_rd_addr == lrm_pkg::FIFO_ADDR) begin
            rd_data = fifo_mem[next_rd_ptr];
        end else if (lr_sel && next_rd_addr == lrm_pkg::FIFO_PTR_ADDR) begin
            rd_data = fifo_ptr;
        end else if (lr_sel) begin
            rd_data = lr_map[next_rd_addr];
        end else begin
            rd_data = fsk_map[next_rd_addr];
        end
    end

    // Load on the byte's last rising edge, shift out on falling edges
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_sh       <= 8'h00;
            spi_miso    <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else begin
            spi_miso_oe <= !nss_f;
            if (byte_ev) begin
                tx_sh <= rd_data;
            end else if (sck_fall) begin
                spi_miso <= tx_sh[7];
                tx_sh    <= {tx_sh[6:0], 1'b0};
            end
        end
    end

    // ****************************************************************
    // Decoding of spreading factor, code rate and bandwidth
    // ****************************************************************
    // Bandwidth table in Hz; out-of-range codes fall back to the widest
    function automatic logic [18:0] bw_to_hz(input logic [3:0] idx);
        case (idx)
            4'h0:    bw_to_hz = 19'd7800;
            4'h1:    bw_to_hz = 19'd10400;
            4'h2:    bw_to_hz = 19'd15600;
            4'h3:    bw_to_hz = 19'd20800;
            4'h4:    bw_to_hz = 19'd31200;
            4'h5:    bw_to_hz = 19'd41700;
            4'h6:    bw_to_hz = 19'd62500;
            4'h7:    bw_to_hz = 19'd125000;
            4'h8:    bw_to_hz = 19'd250000;
            default: bw_to_hz = 19'd500000;
        endcase
    endfunction
    logic [7:0]  cfg1, cfg2;
    logic [3:0]  sf_eff, bw_eff;
    logic [2:0]  cr_eff;
    logic [18:0] bw_hz_eff;
    logic [28:0] bw_milli;
    assign cfg1      = lr_map[lrm_pkg::CFG1_ADDR];
    assign cfg2      = lr_map[lrm_pkg::CFG2_ADDR];
    // Codes outside the legal span clamp so the modem never sees them
    assign sf_eff    = (cfg2[7:4] < lrm_pkg::SF_MIN) ? lrm_pkg::SF_MIN
                     : (cfg2[7:4] > lrm_pkg::SF_MAX) ? lrm_pkg::SF_MAX : cfg2[7:4];
    assign cr_eff    = (cfg1[3:1] < lrm_pkg::CR_MIN) ? lrm_pkg::CR_MIN
                     : (cfg1[3:1] > lrm_pkg::CR_MAX) ? lrm_pkg::CR_MAX : cfg1[3:1];
    assign bw_eff    = (cfg1[7:4] > lrm_pkg::BW_IDX_MAX) ? lrm_pkg::BW_IDX_MAX : cfg1[7:4];
    assign bw_hz_eff = bw_to_hz(bw_eff);
    // Widened before the product so the top bits of 500 kHz times 1000 survive
    assign bw_milli  = 29'(bw_hz_eff) * 29'(lrm_pkg::MILLI_PER_ONE);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_out <= '0;
        end else begin
            cfg_out.spread_exponent   <= sf_eff;
            cfg_out.chips_per_symbol  <= 13'(13'h0001 << sf_eff);
            cfg_out.fec_code_rate     <= cr_eff;
            cfg_out.overhead_quarters <= 4'({1'b0, cr_eff} + lrm_pkg::CR_QUARTERS);
            cfg_out.bw_index          <= bw_eff;
            cfg_out.bw_hz             <= bw_hz_eff;
            cfg_out.sym_rate_mhz      <= bw_milli >> sf_eff;
            cfg_out.headerless        <= cfg1[0];
            cfg_out.cr_in_header      <= !cfg1[0];
            // Highest-rate case armed only once every companion write is in
            cfg_out.sf6_ready <= (sf_eff == lrm_pkg::SF_MIN) && cfg1[0]
                && (lr_map[lrm_pkg::SF6_OPT_ADDR][2:0] == lrm_pkg::SF6_OPT_VAL)
                && (lr_map[lrm_pkg::SF6_THR_ADDR] == lrm_pkg::SF6_THR_VAL);
            cfg_out.long_range        <= lr_sel;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    mode_swap_sleep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $changed(lr_sel) |-> $past(op_mode[2:0]) == lrm_pkg::MODE_SLEEP)
        else $error("modem select changed outside sleep");
    // Settings hold all-zero for one edge after release, so checks wait for it
    sf_range_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(rst_n) |-> cfg_out.spread_exponent inside {[lrm_pkg::SF_MIN:lrm_pkg::SF_MAX]})
        else $error("spreading exponent out of range");
    chips_pow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(rst_n) |-> cfg_out.chips_per_symbol == 13'(13'h0001 << cfg_out.spread_exponent))
        else $error("chips per symbol wrong");
    cr_overhead_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(rst_n) |-> cfg_out.overhead_quarters == 4'({1'b0, cfg_out.fec_code_rate} + 4'h4))
        else $error("code rate overhead wrong");
    header_rate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(rst_n) |-> cfg_out.cr_in_header != cfg_out.headerless)
        else $error("header rate flag wrong");
    sf6_arm_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        cfg_out.sf6_ready |-> cfg_out.headerless && cfg_out.spread_exponent == 4'h6)
        else $error("sf6 armed without its settings");
    sym_rate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(rst_n) |-> cfg_out.sym_rate_mhz
            == (29'(cfg_out.bw_hz) * lrm_pkg::MILLI_PER_ONE) >> cfg_out.spread_exponent)
        else $error("symbol rate wrong");
    fifo_ptr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (data_ev && fifo_hit) |=> fifo_ptr == 8'($past(fifo_ptr) + 8'h01))
        else $error("buffer pointer did not advance");
    map_switch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wr_ev && !lr_sel && addr == lrm_pkg::CFG2_ADDR) |=> $stable(lr_map[lrm_pkg::CFG2_ADDR]))
        else $error("long-range map written while not selected");
endmodule

/* hdl/lrm_pkg.sv */
// Shared constants and types for the long-range modem configuration block
package lrm_pkg;
    // ****************************************************************
    // Register addresses on the serial port
    // ****************************************************************
    localparam logic [6:0] FIFO_ADDR     = 7'h00;
    localparam logic [6:0] OP_MODE_ADDR  = 7'h01;
    localparam logic [6:0] FIFO_PTR_ADDR = 7'h0d;
    localparam logic [6:0] CFG1_ADDR     = 7'h1d;
    localparam logic [6:0] CFG2_ADDR     = 7'h1e;
    localparam logic [6:0] SF6_OPT_ADDR  = 7'h31;
    localparam logic [6:0] SF6_THR_ADDR  = 7'h37;

    // ****************************************************************
    // Field positions, values and reset values
    // ****************************************************************
    localparam int         LR_SEL_BIT    = 7;
    localparam logic [2:0] MODE_SLEEP    = 3'h0;
    localparam logic [7:0] OP_MODE_RST   = 8'h00;
    localparam logic [7:0] CFG1_RST      = 8'h72;
    localparam logic [7:0] CFG2_RST      = 8'h70;
    localparam logic [2:0] SF6_OPT_VAL   = 3'h5;
    localparam logic [7:0] SF6_THR_VAL   = 8'h0c;
    localparam logic [3:0] SF_MIN        = 4'h6;
    localparam logic [3:0] SF_MAX        = 4'hc;
    localparam logic [3:0] BW_IDX_MAX    = 4'h9;
    localparam logic [2:0] CR_MIN        = 3'h1;
    localparam logic [2:0] CR_MAX        = 3'h4;
    localparam logic [3:0] CR_QUARTERS   = 4'h4;
    localparam logic [9:0] MILLI_PER_ONE = 10'h3e8;
    localparam int         MAP_WORDS     = 128;
    localparam int         FIFO_WORDS    = 256;

    // SPI transfer phase
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ADDR = 2'b01,
        PH_DATA = 2'b10
    } lrm_phase_t;

    // Decoded modem settings handed to the modem core
    typedef struct packed {
        logic [3:0]  spread_exponent;   // 6..12
        logic [12:0] chips_per_symbol;  // 2 ** exponent
        logic [2:0]  fec_code_rate;     // 1..4
        logic [3:0]  overhead_quarters; // 5..8 quarters
        logic [3:0]  bw_index;          // 0..9
        logic [18:0] bw_hz;             // double-sideband width
        logic [28:0] sym_rate_mhz;      // symbols per 1000 s
        logic        headerless;        // implicit packets
        logic        cr_in_header;      // rate carried in header
        logic        sf6_ready;         // all highest-rate settings in place
        logic        long_range;        // long-range map selected
    } lrm_cfg_t;
endpackage

/* verif/lrm_spi_host.sv */
// Serial host model that programs the long-range modem over its SPI port
`timescale 1ns/1ps
module lrm_spi_host #(
    parameter int HALF = 6                // Core cycles per SCK half period
) (
    input  wire logic core_clk,           // Time base only
    output logic      spi_sck,            // SPI clock, idle low
    output logic      spi_mosi,           // Data to the device
    output logic      spi_nss_n,          // Select, active low
    input  wire logic spi_miso,           // Data from the device
    input  wire logic spi_miso_oe         // High while the device drives
);
    // Idle pins at time zero
    initial begin
        spi_sck   = 1'b0;
        spi_mosi  = 1'b0;
        spi_nss_n = 1'b1;
    end

    // Pins only move on falling core edges
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic open_frame();
        tick(1);
        spi_nss_n = 1'b0;
        tick(HALF);
    endtask

    // One byte MSB first; miso taken late in the high phase, where it is settled
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi = tx[i];
            tick(HALF);
            spi_sck = 1'b1;
            tick(HALF);
            rx[i] = spi_miso_oe ? spi_miso : ~spi_miso;
            spi_sck = 1'b0;
        end
    endtask

    // Select held over 100 ns past the last fall; released data line is inverted
    task automatic close_frame();
        tick(26);
        spi_nss_n = 1'b1;
        spi_mosi  = ~spi_mosi;
        tick(2 * HALF);
    endtask
endmodule

/* verif/lrm_config_tb.sv */
// Self-checking bench for the long-range modem configuration block
`timescale 1ns/1ps
module lrm_config_tb;
    logic              core_clk = 1'b0;
    logic              nrst     = 1'b0;
    logic              spi_sck;
    logic              spi_mosi;
    logic              spi_nss_n;
    logic              spi_miso;
    logic              spi_miso_oe;
    logic [7:0]        mdm_rd_addr = 8'h00;
    logic [7:0]        mdm_rd_data;
    lrm_pkg::lrm_cfg_t cfg_out;
    int                n_errors = 0;
    int                checks   = 0;
    int                bw_tab [10] = '{7800, 10400, 15600, 20800, 31200,
                                       41700, 62500, 125000, 250000, 500000};

    lrm_config lrm_config_i (.core_clk(core_clk), .nrst(nrst), .spi_sck(spi_sck),
        .spi_mosi(spi_mosi), .spi_nss_n(spi_nss_n), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe), .mdm_rd_addr(mdm_rd_addr),
        .mdm_rd_data(mdm_rd_data), .cfg_out(cfg_out));
    lrm_spi_host lrm_spi_host_i (.core_clk(core_clk), .spi_sck(spi_sck),
        .spi_mosi(spi_mosi), .spi_nss_n(spi_nss_n), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe));

    // 250 MHz core clock
    always #2 core_clk = ~core_clk;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (n_errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] rx;
        lrm_spi_host_i.open_frame();
        lrm_spi_host_i.xbyte({1'b1, a}, rx);
        lrm_spi_host_i.xbyte(d, rx);
        lrm_spi_host_i.close_frame();
    endtask

    // Read one register and compare it
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] rx;
        lrm_spi_host_i.open_frame();
        lrm_spi_host_i.xbyte({1'b0, a}, rx);
        lrm_spi_host_i.xbyte(8'h00, rx);
        lrm_spi_host_i.close_frame();
        chk(32'(rx), 32'(exp));
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        chk(32'(cfg_out.spread_exponent), 7);
        chk(32'(cfg_out.bw_hz), 125000);
        chk(32'(cfg_out.sym_rate_mhz), 976562);
        chk(32'(cfg_out.long_range), 0);
        chk(32'(spi_miso_oe), 0);
        rd_chk(lrm_pkg::OP_MODE_ADDR, 8'h00);
    endtask

    // Mid-run reset puts both maps and the mode back to their defaults
    task automatic t_rearm();
        nrst = 1'b0;
        repeat (4) @(negedge core_clk);
        chk(32'(cfg_out.long_range), 0);
        chk(32'(spi_miso_oe), 0);
        nrst = 1'b1;
        repeat (8) @(negedge core_clk);
        chk(32'(cfg_out.spread_exponent), 7);
        chk(32'(cfg_out.headerless), 0);
        rd_chk(lrm_pkg::CFG2_ADDR, 8'h00);
        rd_chk(lrm_pkg::OP_MODE_ADDR, 8'h00);
    endtask

    // FSK map is plain storage; the modem map keeps its own default
    task automatic t_map_and_mode();
        wr(lrm_pkg::CFG2_ADDR, 8'h55);
        rd_chk(lrm_pkg::CFG2_ADDR, 8'h55);
        chk(32'(cfg_out.spread_exponent), 7);
        wr(lrm_pkg::OP_MODE_ADDR, 8'h81);
        chk(32'(cfg_out.long_range), 1);
        wr(lrm_pkg::OP_MODE_ADDR, 8'h01);
        rd_chk(lrm_pkg::OP_MODE_ADDR, 8'h81);
        wr(lrm_pkg::OP_MODE_ADDR, 8'h80);
        rd_chk(lrm_pkg::OP_MODE_ADDR, 8'h80);
        rd_chk(lrm_pkg::CFG2_ADDR, 8'h70);
    endtask

    // Out-of-range exponents decode clamped; writes are made in Sleep
    task automatic t_spread();
        int ee;
        for (int e = 5; e <= 13; e++) begin
            wr(lrm_pkg::CFG2_ADDR, {4'(e), 4'h0});
            ee = (e < 6) ? 6 : (e > 12) ? 12 : e;
            chk(32'(cfg_out.spread_exponent), ee);
            chk(32'(cfg_out.chips_per_symbol), 1 << ee);
            chk(32'(cfg_out.sym_rate_mhz), 125000000 >> ee);
        end
    endtask

    task automatic t_rate();
        int cc;
        for (int c = 0; c <= 5; c++) begin
            wr(lrm_pkg::CFG1_ADDR, {4'h7, 3'(c), 1'b0});
            cc = (c < 1) ? 1 : (c > 4) ? 4 : c;
            chk(32'(cfg_out.fec_code_rate), cc);
            chk(32'(cfg_out.overhead_quarters), cc + 4);
            chk(32'(cfg_out.cr_in_header), 1);
        end
    endtask

    // Full ladder at exponent 12; 868 MHz band assumed, so all widths allowed
    task automatic t_band();
        wr(lrm_pkg::CFG2_ADDR, 8'hc0);
        for (int b = 0; b <= 9; b++) begin
            wr(lrm_pkg::CFG1_ADDR, {4'(b), 3'h1, 1'b1});
            chk(32'(cfg_out.bw_index), b);
            chk(32'(cfg_out.bw_hz), bw_tab[b]);
            chk(32'(cfg_out.sym_rate_mhz), (bw_tab[b] * 1000) >> 12);
            chk(32'(cfg_out.cr_in_header), 0);
            chk(32'(cfg_out.headerless), 1);
        end
    endtask

    // Highest-rate setup; ready only once every setting is in place
    task automatic t_sf6();
        wr(lrm_pkg::CFG2_ADDR, 8'h60);
        wr(lrm_pkg::CFG1_ADDR, 8'h73);
        wr(lrm_pkg::SF6_OPT_ADDR, 8'hfd);
        chk(32'(cfg_out.sf6_ready), 0);
        wr(lrm_pkg::SF6_THR_ADDR, 8'h0c);
        chk(32'(cfg_out.sf6_ready), 1);
        rd_chk(lrm_pkg::SF6_OPT_ADDR, 8'hfd);
        rd_chk(lrm_pkg::SF6_THR_ADDR, 8'h0c);
        wr(lrm_pkg::SF6_THR_ADDR, 8'h0d);
        chk(32'(cfg_out.sf6_ready), 0);
        wr(lrm_pkg::SF6_THR_ADDR, 8'h0c);
        wr(lrm_pkg::CFG1_ADDR, 8'h72);
        chk(32'(cfg_out.sf6_ready), 0);
    endtask

    // Burst into the buffer, read it at the modem port and back over SPI
    task automatic t_buffer();
        logic [7:0] rx;
        wr(lrm_pkg::FIFO_PTR_ADDR, 8'h10);
        lrm_spi_host_i.open_frame();
        lrm_spi_host_i.xbyte({1'b1, lrm_pkg::FIFO_ADDR}, rx);
        for (int i = 0; i < 3; i++) lrm_spi_host_i.xbyte(8'ha0 + 8'(i), rx);
        lrm_spi_host_i.close_frame();
        rd_chk(lrm_pkg::FIFO_PTR_ADDR, 8'h13);
        for (int i = 0; i < 3; i++) begin
            mdm_rd_addr = 8'h10 + 8'(i);
            @(negedge core_clk);
            chk(32'(mdm_rd_data), 32'h0a0 + i);
        end
        wr(lrm_pkg::FIFO_PTR_ADDR, 8'h10);
        lrm_spi_host_i.open_frame();
        lrm_spi_host_i.xbyte({1'b0, lrm_pkg::FIFO_ADDR}, rx);
        for (int i = 0; i < 3; i++) begin
            lrm_spi_host_i.xbyte(8'h00, rx);
            chk(32'(rx), 32'h0a0 + i);
        end
        lrm_spi_host_i.close_frame();
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (20) @(negedge core_clk);
        nrst = 1'b1;
        repeat (8) @(negedge core_clk);
        t_reset();
        t_map_and_mode();
        t_spread();
        t_rate();
        t_band();
        t_sf6();
        t_buffer();
        t_rearm();
        conclude();
    end

    // Watchdog so a stuck port cannot hang the run
    initial begin
        repeat (100000) @(posedge core_clk);
        n_errors++;
        conclude();
    end
endmodule
